// >>> common/pg_pkg.sv
// Constants, addresses and reset values of the six-pin general-purpose port.
// Assumes a 32-bit address, 8-bit data register port clocked by sys_clk.
//
// Summary of operation
// RULE1 - The port has six pins, each independently set up as an input or an output.
// RULE2 - Each pin's direction comes from its own bit in the direction register.
// RULE3 - Each pin's bit in the function-select register picks plain port use or its alternate.
// RULE4 - Each pin has a pull-up that its own bit in the pull-up enable register switches on.
// RULE5 - Per-pin rising and falling select bits decide which edges count as interrupt events.
// RULE6 - The data register is eight bits, byte or single-bit accessible, reads pins, writes outputs; pins set as outputs read back the latch.
// RULE7 - A data write always updates the latch, while pins set as inputs stay unaffected.
// RULE8 - In alternate use pin 0 feeds the NMI, pins 1 to 4 interrupts or timers, pin 5 an interrupt.
// RULE9 - An output pin drives its latch bit, and data bits 7 and 6 read zero and ignore writes.
package pg_pkg;
  localparam int PIN_W = 6;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 32;
  localparam int BIT_SEL_W = 3;

  localparam logic [ADDR_W-1:0] ADDR_DATA = 32'hfffff400;
  localparam logic [ADDR_W-1:0] ADDR_DIR = 32'hfffff420;
  localparam logic [ADDR_W-1:0] ADDR_FUNC = 32'hfffff440;
  localparam logic [ADDR_W-1:0] ADDR_PULLUP = 32'hfffffc40;
  localparam logic [ADDR_W-1:0] ADDR_RISE = 32'hfffffc20;
  localparam logic [ADDR_W-1:0] ADDR_FALL = 32'hfffffc00;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 32'hfffffc60;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 32'hfffffc61;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 32'hfffffc62;

  localparam logic [PIN_W-1:0] RST_LATCH = 6'h00;
  localparam logic [PIN_W-1:0] RST_DIR = 6'h3f;
  localparam logic [PIN_W-1:0] RST_FUNC = 6'h00;
  localparam logic [PIN_W-1:0] RST_PULLUP = 6'h00;
  localparam logic [PIN_W-1:0] RST_EDGE = 6'h00;
  localparam logic [PIN_W-1:0] RST_IRQ = 6'h00;
  localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;

  // Unused upper bits of the direction register read as ones, others as zero.
  localparam logic [1:0] DIR_PAD = 2'h3;
  localparam logic [1:0] ZERO_PAD = 2'h0;

  localparam int PIN_NMI = 0;
  localparam int PIN_INT_A = 1;
  localparam int PIN_INT_E = 5;
  localparam int PIN_INT_B = 2;
  localparam int PIN_INT_C = 3;
  localparam int PIN_INT_D = 4;
  localparam int PIN_TMR_A = 1;
  localparam int PIN_TMR_B = 2;
  localparam int PIN_TMR_C = 3;
  localparam int PIN_TMR_D = 4;
  localparam logic RST_IRQ_LINE = 1'b0;
endpackage

// >>> common/pg_evt_if.sv
// Carries pin levels and edge settings into the edge detector, and events back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pg_evt_if;
  logic [pg_pkg::PIN_W-1:0] pin_lvl;
  logic [pg_pkg::PIN_W-1:0] alt_sel;
  logic [pg_pkg::PIN_W-1:0] rise_sel;
  logic [pg_pkg::PIN_W-1:0] fall_sel;
  logic [pg_pkg::PIN_W-1:0] event_pulse;
  modport port_side (
    output pin_lvl,
    output alt_sel,
    output rise_sel,
    output fall_sel,
    input event_pulse
  );
  modport edge_side (
    input pin_lvl,
    input alt_sel,
    input rise_sel,
    input fall_sel,
    output event_pulse
  );
endinterface

// >>> src/pg_edge_detect.sv
// Edge detector for the external interrupt inputs of the port.
// Assumes pin levels arrive already synchronous to sys_clk.
`timescale 1ns/1ps
module pg_edge_detect (
  input wire logic sys_clk,
  input wire logic rst_n,
  pg_evt_if.edge_side evt
);
  logic [pg_pkg::PIN_W-1:0] prev_r;
  logic [pg_pkg::PIN_W-1:0] prev_nxt;
  logic [pg_pkg::PIN_W-1:0] event_r;
  logic [pg_pkg::PIN_W-1:0] event_nxt;

  ////////////////////////////////////////////////////////////////////////////////
  // Pins outside alternate use never raise events, so a plain port toggling
  // cannot disturb the interrupt status.
  always_comb begin
    prev_nxt = evt.pin_lvl;
    event_nxt = evt.alt_sel & ((evt.rise_sel & evt.pin_lvl & ~prev_r) |
                               (evt.fall_sel & ~evt.pin_lvl & prev_r)); // RULE5
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= pg_pkg::RST_EDGE;
      event_r <= pg_pkg::RST_EDGE;
    end else begin
      prev_r <= prev_nxt;
      event_r <= event_nxt;
    end
  end

  assign evt.event_pulse = event_r;
endmodule

// >>> src/pg_port0.sv
// Six-pin general-purpose port with direction, alternate function, pull-up,
// interrupt edge selection and an interrupt status block.
// Assumes a single-cycle register port and pin inputs synchronous to sys_clk.
`timescale 1ns/1ps
module pg_port0 (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [pg_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [pg_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_bit_mode,
  input wire logic [pg_pkg::BIT_SEL_W-1:0] bus_bit_sel,
  output logic [pg_pkg::DATA_W-1:0] bus_rdata,
  input wire logic [pg_pkg::PIN_W-1:0] pin_in,
  output logic [pg_pkg::PIN_W-1:0] pin_out,
  output logic [pg_pkg::PIN_W-1:0] pin_oe_n,
  output logic [pg_pkg::PIN_W-1:0] pin_pullup_en,
  output logic nmi_in,
  output logic ext_interrupt_in_a,
  output logic ext_interrupt_in_b,
  output logic ext_interrupt_in_c,
  output logic ext_interrupt_in_d,
  output logic ext_interrupt_in_e,
  output logic timer_capture_in_a,
  output logic timer_capture_in_b,
  output logic timer_capture_in_c,
  output logic timer_capture_in_d,
  output logic [pg_pkg::PIN_W-1:0] ext_event,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////////
  // Byte writes replace the whole register; single-bit writes take bit 0 of
  // the write data into the selected bit only, as a set or clear instruction.
  function automatic logic [pg_pkg::DATA_W-1:0] merge_write(
    input logic [pg_pkg::DATA_W-1:0] old_val,
    input logic [pg_pkg::DATA_W-1:0] wdata,
    input logic bit_mode,
    input logic [pg_pkg::BIT_SEL_W-1:0] bit_sel
  );
    logic [pg_pkg::DATA_W-1:0] res;
    res = old_val;
    if (bit_mode) begin
      res[bit_sel] = wdata[0];
    end else begin
      res = wdata;
    end
    return res;
  endfunction

  // Single-bit reads return the selected bit in bit 0.
  function automatic logic [pg_pkg::DATA_W-1:0] shape_read(
    input logic [pg_pkg::DATA_W-1:0] val,
    input logic bit_mode,
    input logic [pg_pkg::BIT_SEL_W-1:0] bit_sel
  );
    logic [pg_pkg::DATA_W-1:0] res;
    res = val;
    if (bit_mode) begin
      res = {7'h00, val[bit_sel]};
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [pg_pkg::PIN_W-1:0] latch_r;
  logic [pg_pkg::PIN_W-1:0] latch_nxt;
  logic [pg_pkg::PIN_W-1:0] dir_r;
  logic [pg_pkg::PIN_W-1:0] dir_nxt;
  logic [pg_pkg::PIN_W-1:0] func_r;
  logic [pg_pkg::PIN_W-1:0] func_nxt;
  logic [pg_pkg::PIN_W-1:0] pullup_r;
  logic [pg_pkg::PIN_W-1:0] pullup_nxt;
  logic [pg_pkg::PIN_W-1:0] rise_r;
  logic [pg_pkg::PIN_W-1:0] rise_nxt;
  logic [pg_pkg::PIN_W-1:0] fall_r;
  logic [pg_pkg::PIN_W-1:0] fall_nxt;
  logic [pg_pkg::PIN_W-1:0] status_r;
  logic [pg_pkg::PIN_W-1:0] status_nxt;
  logic [pg_pkg::PIN_W-1:0] enable_r;
  logic [pg_pkg::PIN_W-1:0] enable_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [pg_pkg::DATA_W-1:0] rdata_r;
  logic [pg_pkg::DATA_W-1:0] rdata_nxt;
  logic [pg_pkg::PIN_W-1:0] oe_n_r;
  logic [pg_pkg::PIN_W-1:0] oe_n_nxt;
  logic [pg_pkg::PIN_W-1:0] alt_lvl_r;
  logic [pg_pkg::PIN_W-1:0] alt_lvl_nxt;
  logic [pg_pkg::PIN_W-1:0] event_r;
  logic [pg_pkg::PIN_W-1:0] event_nxt;
  logic [pg_pkg::PIN_W-1:0] data_view;
  logic [pg_pkg::DATA_W-1:0] merged;
  logic [pg_pkg::DATA_W-1:0] clr_mask;

  pg_evt_if evt ();

  ////////////////////////////////////////////////////////////////////////////////
  // Edge detection for pins in alternate use.
  assign evt.pin_lvl = pin_in;
  assign evt.alt_sel = func_r;
  assign evt.rise_sel = rise_r;
  assign evt.fall_sel = fall_r;

  pg_edge_detect u_edge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .evt(evt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reading the data register shows the pin in input mode and the latch in
  // output mode, so software sees what it wrote even under a heavy pin load.
  always_comb begin
    data_view = (dir_r & pin_in) | (~dir_r & latch_r); // RULE6
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_comb begin
    latch_nxt = latch_r;
    dir_nxt = dir_r;
    func_nxt = func_r;
    pullup_nxt = pullup_r;
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    enable_nxt = enable_r;
    clr_mask = 8'h00;
    merged = 8'h00;
    if (bus_wr) begin
      unique case (bus_addr)
        pg_pkg::ADDR_DATA: begin
          // The latch updates even for input pins; it only reaches the pin
          // once the direction turns to output.
          merged = merge_write({pg_pkg::ZERO_PAD, latch_r}, bus_wdata, bus_bit_mode,
                               bus_bit_sel); // RULE6
          latch_nxt = merged[pg_pkg::PIN_W-1:0]; // RULE7 RULE9
        end
        pg_pkg::ADDR_DIR: begin
          merged = merge_write({pg_pkg::DIR_PAD, dir_r}, bus_wdata, bus_bit_mode,
                               bus_bit_sel);
          dir_nxt = merged[pg_pkg::PIN_W-1:0]; // RULE2
        end
        pg_pkg::ADDR_FUNC: begin
          merged = merge_write({pg_pkg::ZERO_PAD, func_r}, bus_wdata, bus_bit_mode,
                               bus_bit_sel);
          func_nxt = merged[pg_pkg::PIN_W-1:0]; // RULE3
        end
        pg_pkg::ADDR_PULLUP: begin
          merged = merge_write({pg_pkg::ZERO_PAD, pullup_r}, bus_wdata, bus_bit_mode,
                               bus_bit_sel);
          pullup_nxt = merged[pg_pkg::PIN_W-1:0]; // RULE4
        end
        pg_pkg::ADDR_RISE: begin
          merged = merge_write({pg_pkg::ZERO_PAD, rise_r}, bus_wdata, bus_bit_mode,
                               bus_bit_sel);
          rise_nxt = merged[pg_pkg::PIN_W-1:0]; // RULE5
        end
        pg_pkg::ADDR_FALL: begin
          merged = merge_write({pg_pkg::ZERO_PAD, fall_r}, bus_wdata, bus_bit_mode,
                               bus_bit_sel);
          fall_nxt = merged[pg_pkg::PIN_W-1:0]; // RULE5
        end
        pg_pkg::ADDR_IRQ_CLEAR: begin
          clr_mask = merge_write(8'h00, bus_wdata, bus_bit_mode, bus_bit_sel);
        end
        pg_pkg::ADDR_IRQ_ENABLE: begin
          merged = merge_write({pg_pkg::ZERO_PAD, enable_r}, bus_wdata, bus_bit_mode,
                               bus_bit_sel);
          enable_nxt = merged[pg_pkg::PIN_W-1:0];
        end
        default: begin
          merged = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status: a new event wins over a clear in the same cycle.
  always_comb begin
    event_nxt = evt.event_pulse;
    status_nxt = (status_r & ~clr_mask[pg_pkg::PIN_W-1:0]) | evt.event_pulse; // RULE5
    irq_nxt = |(status_nxt & enable_nxt);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the read strobe only.
  always_comb begin
    rdata_nxt = pg_pkg::RST_RDATA;
    if (bus_rd) begin
      unique case (bus_addr)
        pg_pkg::ADDR_DATA: begin
          rdata_nxt = shape_read({pg_pkg::ZERO_PAD, data_view}, bus_bit_mode,
                                 bus_bit_sel); // RULE6 RULE9
        end
        pg_pkg::ADDR_DIR: begin
          rdata_nxt = shape_read({pg_pkg::DIR_PAD, dir_r}, bus_bit_mode, bus_bit_sel);
        end
        pg_pkg::ADDR_FUNC: begin
          rdata_nxt = shape_read({pg_pkg::ZERO_PAD, func_r}, bus_bit_mode, bus_bit_sel);
        end
        pg_pkg::ADDR_PULLUP: begin
          rdata_nxt = shape_read({pg_pkg::ZERO_PAD, pullup_r}, bus_bit_mode, bus_bit_sel);
        end
        pg_pkg::ADDR_RISE: begin
          rdata_nxt = shape_read({pg_pkg::ZERO_PAD, rise_r}, bus_bit_mode, bus_bit_sel);
        end
        pg_pkg::ADDR_FALL: begin
          rdata_nxt = shape_read({pg_pkg::ZERO_PAD, fall_r}, bus_bit_mode, bus_bit_sel);
        end
        pg_pkg::ADDR_IRQ_STATUS: begin
          rdata_nxt = shape_read({pg_pkg::ZERO_PAD, status_r}, bus_bit_mode, bus_bit_sel);
        end
        pg_pkg::ADDR_IRQ_ENABLE: begin
          rdata_nxt = shape_read({pg_pkg::ZERO_PAD, enable_r}, bus_bit_mode, bus_bit_sel);
        end
        default: begin
          rdata_nxt = pg_pkg::RST_RDATA;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive and alternate routing. A pin in alternate use is always an
  // input here, since every alternate of this port is an input function.
  always_comb begin
    oe_n_nxt = dir_nxt | func_nxt; // RULE1 RULE2 RULE3
    alt_lvl_nxt = pin_in & func_r; // RULE8
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= pg_pkg::RST_LATCH;
      dir_r <= pg_pkg::RST_DIR;
      func_r <= pg_pkg::RST_FUNC;
      pullup_r <= pg_pkg::RST_PULLUP;
      rise_r <= pg_pkg::RST_EDGE;
      fall_r <= pg_pkg::RST_EDGE;
      enable_r <= pg_pkg::RST_IRQ;
    end else begin
      latch_r <= latch_nxt;
      dir_r <= dir_nxt;
      func_r <= func_nxt;
      pullup_r <= pullup_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
      enable_r <= enable_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, event output and interrupt line.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= pg_pkg::RST_IRQ;
      irq_r <= pg_pkg::RST_IRQ_LINE;
      event_r <= pg_pkg::RST_IRQ;
    end else begin
      status_r <= status_nxt;
      irq_r <= irq_nxt;
      event_r <= event_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data register.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= pg_pkg::RST_RDATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin enables and alternate levels.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_n_r <= pg_pkg::RST_DIR;
      alt_lvl_r <= pg_pkg::RST_FUNC;
    end else begin
      oe_n_r <= oe_n_nxt;
      alt_lvl_r <= alt_lvl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign bus_rdata = rdata_r;
  assign pin_out = latch_r; // RULE9
  assign pin_oe_n = oe_n_r;
  assign pin_pullup_en = pullup_r; // RULE4
  assign nmi_in = alt_lvl_r[pg_pkg::PIN_NMI]; // RULE8
  assign ext_interrupt_in_a = alt_lvl_r[pg_pkg::PIN_INT_A];
  assign ext_interrupt_in_b = alt_lvl_r[pg_pkg::PIN_INT_B];
  assign ext_interrupt_in_c = alt_lvl_r[pg_pkg::PIN_INT_C];
  assign ext_interrupt_in_d = alt_lvl_r[pg_pkg::PIN_INT_D];
  assign ext_interrupt_in_e = alt_lvl_r[pg_pkg::PIN_INT_E];
  assign timer_capture_in_a = alt_lvl_r[pg_pkg::PIN_TMR_A];
  assign timer_capture_in_b = alt_lvl_r[pg_pkg::PIN_TMR_B];
  assign timer_capture_in_c = alt_lvl_r[pg_pkg::PIN_TMR_C];
  assign timer_capture_in_d = alt_lvl_r[pg_pkg::PIN_TMR_D];
  assign ext_event = event_r;
  assign irq = irq_r;
endmodule

// >>> verif/pg_port0_sva.sv
// Concurrent checks on the register port and pin behaviour of the six-pin port.
// Assumes it is bound to pg_port0 and sees only that module's ports.
`timescale 1ns/1ps
module pg_port0_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [pg_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [pg_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_bit_mode,
  input wire logic [pg_pkg::BIT_SEL_W-1:0] bus_bit_sel,
  input wire logic [pg_pkg::DATA_W-1:0] bus_rdata,
  input wire logic [pg_pkg::PIN_W-1:0] pin_in,
  input wire logic [pg_pkg::PIN_W-1:0] pin_out,
  input wire logic [pg_pkg::PIN_W-1:0] pin_oe_n,
  input wire logic [pg_pkg::PIN_W-1:0] pin_pullup_en,
  input wire logic nmi_in,
  input wire logic ext_interrupt_in_a,
  input wire logic ext_interrupt_in_e,
  input wire logic timer_capture_in_a,
  input wire logic [pg_pkg::PIN_W-1:0] ext_event,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic wr_data;
  assign wr_data = bus_wr && bus_addr == pg_pkg::ADDR_DATA;
  //////////////////////////////////////////////////
  property p_rd_idle; !$past(bus_rd) |-> bus_rdata == 8'h00; endproperty
  property p_rd_pad; $past(bus_rd && bus_addr == pg_pkg::ADDR_DATA) |-> bus_rdata[7:6] == 2'h0;
  endproperty
  property p_wr_byte; wr_data && !bus_bit_mode |=> pin_out == $past(bus_wdata[5:0]); endproperty
  property p_wr_bit; wr_data && bus_bit_mode && bus_bit_sel < 3'h6
    |=> pin_out[$past(bus_bit_sel)] == $past(bus_wdata[0]); endproperty
  property p_keep_dir; wr_data |=> $stable(pin_oe_n); endproperty
  property p_dir; bus_wr && bus_addr == pg_pkg::ADDR_DIR && !bus_bit_mode
    |=> (pin_oe_n | ~$past(bus_wdata[5:0])) == 6'h3f; endproperty
  property p_func; bus_wr && bus_addr == pg_pkg::ADDR_FUNC && !bus_bit_mode
    && bus_wdata[5:0] == 6'h3f |=> pin_oe_n == 6'h3f; endproperty
  property p_pull; bus_wr && bus_addr == pg_pkg::ADDR_PULLUP && !bus_bit_mode
    |=> pin_pullup_en == $past(bus_wdata[5:0]); endproperty
  property p_nmi; !$past(pin_in[0]) |-> !nmi_in; endproperty
  property p_int_e; !$past(pin_in[5]) |-> !ext_interrupt_in_e; endproperty
  property p_pair; ext_interrupt_in_a == timer_capture_in_a; endproperty
  property p_evt; (ext_event & ~($past(pin_in, 2) ^ $past(pin_in, 3))) == 6'h00; endproperty
  //////////////////////////////////////////////////
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_rd_pad: assert property (p_rd_pad) else $error("data bits 7 and 6 not zero");
  a_wr_byte: assert property (p_wr_byte) else $error("latch missed byte write");
  a_wr_bit: assert property (p_wr_bit) else $error("latch missed bit write");
  a_keep_dir: assert property (p_keep_dir) else $error("data write moved enables");
  a_dir: assert property (p_dir) else $error("input pin still driven");
  a_func: assert property (p_func) else $error("alternate pin still driven");
  a_pull: assert property (p_pull) else $error("pull-up enables wrong");
  a_nmi: assert property (p_nmi) else $error("nmi high with pin low");
  a_int_e: assert property (p_int_e) else $error("pin 5 interrupt high with pin low");
  a_pair: assert property (p_pair) else $error("pin 1 alternates disagree");
  a_evt: assert property (p_evt) else $error("event without pin edge");
  c_evt: cover property (ext_event != 6'h00);
  c_irq: cover property ($rose(irq));
  c_bit: cover property (wr_data && bus_bit_mode);
endmodule
bind pg_port0 pg_port0_sva i_sva (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bit_mode(bus_bit_mode),
  .bus_bit_sel(bus_bit_sel), .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en), .nmi_in(nmi_in),
  .ext_interrupt_in_a(ext_interrupt_in_a), .ext_interrupt_in_e(ext_interrupt_in_e),
  .timer_capture_in_a(timer_capture_in_a), .ext_event(ext_event), .irq(irq));

// >>> verif/pg_board.sv
// Board model for the six port pins: resolves port drive, board drive and pull-ups.
// Assumes board drive values change just after a rising edge of sys_clk.
`timescale 1ns/1ps
module pg_board (
  input wire logic sys_clk,
  input wire logic [pg_pkg::PIN_W-1:0] pin_out,
  input wire logic [pg_pkg::PIN_W-1:0] pin_oe_n,
  input wire logic [pg_pkg::PIN_W-1:0] pin_pullup_en,
  input wire logic [pg_pkg::PIN_W-1:0] drv_val,
  input wire logic [pg_pkg::PIN_W-1:0] drv_en,
  output logic [pg_pkg::PIN_W-1:0] pin_lvl
);
  // An undriven pin without pull-up toggles, so no read can pass by luck.
  logic [pg_pkg::PIN_W-1:0] float_r = 6'h15;
  always @(posedge sys_clk) float_r <= ~float_r;
  always_comb begin
    for (int k = 0; k < pg_pkg::PIN_W; k++) begin
      if (!pin_oe_n[k]) pin_lvl[k] = pin_out[k];
      else if (drv_en[k]) pin_lvl[k] = drv_val[k];
      else if (pin_pullup_en[k]) pin_lvl[k] = 1'b1;
      else pin_lvl[k] = float_r[k];
    end
  end
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the six-pin port, driving its register port and board pins.
// Assumes pg_port0, pg_board and the bound checker are compiled before it.
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] bus_addr = 32'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic bus_bit_mode = 1'b0;
  logic [2:0] bus_bit_sel = 3'h0;
  logic [7:0] bus_rdata;
  logic [5:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, ext_event;
  logic [5:1] ext_i;
  logic [4:1] ext_t;
  logic [5:0] drv_val = 6'h00;
  logic [5:0] drv_en = 6'h00;
  logic nmi_in, irq;
  int failures = 0;
  int num_checks = 0;
  always #2 sys_clk = ~sys_clk;
  pg_port0 i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_bit_mode(bus_bit_mode), .bus_bit_sel(bus_bit_sel),
    .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .nmi_in(nmi_in), .ext_interrupt_in_a(ext_i[1]),
    .ext_interrupt_in_b(ext_i[2]), .ext_interrupt_in_c(ext_i[3]), .ext_interrupt_in_d(ext_i[4]),
    .ext_interrupt_in_e(ext_i[5]), .timer_capture_in_a(ext_t[1]), .timer_capture_in_b(ext_t[2]),
    .timer_capture_in_c(ext_t[3]), .timer_capture_in_d(ext_t[4]), .ext_event(ext_event),
    .irq(irq));
  pg_board i_board (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .drv_val(drv_val), .drv_en(drv_en), .pin_lvl(pin_in));
  //////////////////////////////////////////////////
  task automatic summarize();
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic acc(input logic rd_en, input logic [31:0] a, input logic [7:0] d,
                     input logic bm, input logic [2:0] s);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_bit_mode <= bm;
    bus_bit_sel <= s;
    bus_rd <= rd_en;
    bus_wr <= !rd_en;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
    #1;
    if (rd_en) chk($sformatf("read %h", a), d, bus_rdata);
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic bm = 1'b0,
                    input logic [2:0] s = 3'h0);
    acc(1'b0, a, d, bm, s);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] exp, input logic bm = 1'b0,
                    input logic [2:0] s = 3'h0);
    acc(1'b1, a, exp, bm, s);
  endtask
  task automatic drive(input logic [5:0] v);
    @(posedge sys_clk);
    drv_en <= 6'h3f;
    drv_val <= v;
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 10; k++) begin
      @(posedge sys_clk);
      #1;
      if (irq === 1'b1) return;
    end
    failures++;
    $display("ERROR irq expected 1 seen %b", irq);
    summarize();
  endtask
  //////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(pg_pkg::ADDR_DIR, 8'hff);
    rd(32'hfffff404, 8'h00);
    wr(pg_pkg::ADDR_PULLUP, 8'h3f);
    chk("pullup", 8'h3f, {2'h0, pin_pullup_en});
    rd(pg_pkg::ADDR_PULLUP, 8'h3f);
    rd(pg_pkg::ADDR_DATA, 8'h3f);
    wr(pg_pkg::ADDR_DATA, 8'h15);
    chk("latch", 8'h15, {2'h0, pin_out});
    rd(pg_pkg::ADDR_DATA, 8'h3f);
    wr(pg_pkg::ADDR_DIR, 8'h00);
    chk("oe_n", 8'h00, {2'h0, pin_oe_n});
    rd(pg_pkg::ADDR_DATA, 8'h15);
    wr(pg_pkg::ADDR_DATA, 8'hea);
    rd(pg_pkg::ADDR_DATA, 8'h2a);
    wr(pg_pkg::ADDR_DATA, 8'h01, 1'b1, 3'h0);
    wr(pg_pkg::ADDR_DATA, 8'h00, 1'b1, 3'h5);
    wr(pg_pkg::ADDR_DATA, 8'h01, 1'b1, 3'h7);
    rd(pg_pkg::ADDR_DATA, 8'h0b);
    rd(pg_pkg::ADDR_DATA, 8'h01, 1'b1, 3'h1);
    wr(pg_pkg::ADDR_DIR, 8'h38);
    drive(6'h00);
    rd(pg_pkg::ADDR_DATA, 8'h03);
    wr(pg_pkg::ADDR_FUNC, 8'h3f);
    chk("oe_n", 8'h3f, {2'h0, pin_oe_n});
    rd(pg_pkg::ADDR_FUNC, 8'h3f);
    drive(6'h3f);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("alt_int", 8'h3f, {2'h0, ext_i, nmi_in});
    chk("alt_tmr", 8'h0f, {4'h0, ext_t});
    rd(pg_pkg::ADDR_IRQ_STATUS, 8'h00);
    wr(pg_pkg::ADDR_RISE, 8'h02);
    rd(pg_pkg::ADDR_RISE, 8'h02);
    wr(pg_pkg::ADDR_IRQ_ENABLE, 8'h02);
    drive(6'h00);
    repeat (3) @(posedge sys_clk);
    rd(pg_pkg::ADDR_IRQ_STATUS, 8'h00);
    drive(6'h02);
    wait_irq();
    chk("event", 8'h02, {2'h0, ext_event});
    rd(pg_pkg::ADDR_IRQ_STATUS, 8'h02);
    wr(pg_pkg::ADDR_IRQ_CLEAR, 8'h02);
    chk("irq", 8'h00, {7'h0, irq});
    wr(pg_pkg::ADDR_IRQ_ENABLE, 8'h00);
    wr(pg_pkg::ADDR_FALL, 8'h02);
    rd(pg_pkg::ADDR_FALL, 8'h02);
    drive(6'h00);
    repeat (3) @(posedge sys_clk);
    rd(pg_pkg::ADDR_IRQ_STATUS, 8'h02);
    chk("irq", 8'h00, {7'h0, irq});
    wr(pg_pkg::ADDR_IRQ_ENABLE, 8'h02);
    chk("irq", 8'h01, {7'h0, irq});
    rd(pg_pkg::ADDR_IRQ_ENABLE, 8'h02);
    wr(pg_pkg::ADDR_IRQ_CLEAR, 8'h01, 1'b1, 3'h1);
    chk("irq", 8'h00, {7'h0, irq});
    rd(pg_pkg::ADDR_IRQ_STATUS, 8'h00);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(pg_pkg::ADDR_FUNC, 8'h00);
    chk("oe_n", 8'h3f, {2'h0, pin_oe_n});
    chk("pullup", 8'h00, {2'h0, pin_pullup_en});
    summarize();
  end
endmodule
